/* core/serial_control_port.v */
// spi / i2c slave control port with interrupt pin
`timescale 1ns/1ps
`include "serial_control_port_consts.vh"
module serial_control_port #(
  parameter N_IRQ = 8
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire control_bit_clock_i,
  input wire control_serial_in_i,
  input wire sda_i,
  input wire addr0_or_select_pin_i,
  input wire address_bit1_pin_i,
  input wire emphasis_flag_pin_i,
  input wire [7:0] reg_rdata_i,
  input wire [1:0] irq_pin_drive_select_i,
  input wire [N_IRQ-1:0] irq_cond_i,
  input wire [N_IRQ-1:0] irq_mask_i,
  input wire [2*N_IRQ-1:0] irq_trig_i,
  input wire [N_IRQ-1:0] irq_clear_i,
  output reg control_serial_out_o,
  output reg control_serial_out_oe_n_o,
  output reg sda_o,
  output reg sda_oe_n_o,
  output reg [6:0] reg_addr_o,
  output reg [7:0] reg_wdata_o,
  output reg reg_write_o,
  output reg reg_read_o,
  output reg [1:0] port_mode_o,
  output reg pointer_auto_step_o,
  output reg irq_o,
  output reg irq_oe_n_o,
  output reg [N_IRQ-1:0] irq_status_o
);
  // two-flop synchronisers, all pins except the emphasis strap
  reg [1:0] s_clk, s_din, s_sda, s_sel, s_ad1;
  reg clk_d, sda_d, sel_d;
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_clk <= 2'b11; // bit clock idles high, so no false edge after reset
      s_din <= 2'b00;
      s_ad1 <= 2'b00;
      s_sda <= 2'b11;
      s_sel <= 2'b11;
      clk_d <= 1'b1;
      sda_d <= 1'b1;
      sel_d <= 1'b1;
    end else begin
      s_clk <= {s_clk[0], control_bit_clock_i};
      s_din <= {s_din[0], control_serial_in_i};
      s_sda <= {s_sda[0], sda_i};
      s_sel <= {s_sel[0], addr0_or_select_pin_i};
      s_ad1 <= {s_ad1[0], address_bit1_pin_i};
      clk_d <= s_clk[1];
      sda_d <= s_sda[1];
      sel_d <= s_sel[1];
    end
  end
  wire clk_s = s_clk[1];
  wire rise = clk_s & ~clk_d;
  wire fall = ~clk_s & clk_d;
  wire sel_s = s_sel[1];
  wire sel_fall = ~sel_s & sel_d;
  wire sel_rise = sel_s & ~sel_d;
  wire start = clk_s & sda_d & ~s_sda[1];
  wire stop = clk_s & ~sda_d & s_sda[1];
  // strap capture while held in reset
  reg strap2;
  always @(posedge clock_i) begin
    if (!rst_n_i)
      strap2 <= emphasis_flag_pin_i;
  end
  localparam ST_ADDR = 3'd0, ST_PTR = 3'd1, ST_DATA = 3'd2, ST_READ = 3'd3,
             ST_IDLE = 3'd4, ST_ACK = 3'd5, ST_RACK = 3'd6;
  reg [2:0] state, after_ack;
  reg [2:0] bits;
  reg [7:0] shift, tx;
  reg rw, mode_locked;
  wire [6:0] i2c_addr = {`I2C_ADDR_HI, strap2, s_ad1[1], sel_s};
  wire [7:0] byte_in = {shift[6:0], (port_mode_o == `MODE_SPI) ? s_din[1] : s_sda[1]};
  wire step = pointer_auto_step_o;
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      after_ack <= ST_IDLE;
      bits <= 3'd0;
      shift <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      mode_locked <= 1'b0;
      port_mode_o <= `MODE_NONE;
      reg_addr_o <= 7'h00;
      pointer_auto_step_o <= 1'b0;
      reg_wdata_o <= 8'h00;
      reg_write_o <= 1'b0;
      reg_read_o <= 1'b0;
      control_serial_out_o <= 1'b0;
      control_serial_out_oe_n_o <= 1'b1;
      sda_o <= 1'b0;
      sda_oe_n_o <= 1'b1;
    end else begin
      reg_write_o <= 1'b0;
      reg_read_o <= 1'b0;
      if (!mode_locked) begin
        if (sel_fall) begin
          port_mode_o <= `MODE_SPI;
          mode_locked <= 1'b1;
          state <= ST_ADDR;
          bits <= 3'd0;
        end else if (start) begin
          port_mode_o <= `MODE_I2C;
          mode_locked <= 1'b1;
          state <= ST_ADDR;
          bits <= 3'd0;
        end
      end else if (port_mode_o == `MODE_SPI) begin
        if (sel_s) begin
          state <= ST_ADDR;
          bits <= 3'd0;
          control_serial_out_oe_n_o <= 1'b1;
        end else if (rise && state != ST_READ && state != ST_IDLE) begin
          shift <= byte_in;
          bits <= bits + 3'd1;
          if (bits == 3'd7) begin
            case (state)
              ST_ADDR: begin
                if (byte_in[7:1] == `SPI_CHIP_ADDR) begin
                  rw <= byte_in[0];
                  state <= byte_in[0] ? ST_READ : ST_PTR;
                  tx <= reg_rdata_i;
                  reg_read_o <= byte_in[0];
                end else
                  state <= ST_IDLE;
              end
              ST_PTR: begin
                pointer_auto_step_o <= byte_in[`PTR_STEP_BIT];
                reg_addr_o <= byte_in[6:0];
                state <= ST_DATA;
              end
              ST_DATA: begin
                reg_wdata_o <= byte_in;
                reg_write_o <= 1'b1;
              end
              default: state <= ST_IDLE;
            endcase
          end
        end else if (state == ST_DATA && reg_write_o && step) begin
          reg_addr_o <= reg_addr_o + 7'd1;
        end else if (state == ST_READ && fall) begin
          control_serial_out_oe_n_o <= 1'b0;
          control_serial_out_o <= tx[7];
          tx <= {tx[6:0], 1'b0};
          bits <= bits + 3'd1;
          if (bits == 3'd7) begin
            if (step)
              reg_addr_o <= reg_addr_o + 7'd1;
          end
        end else if (state == ST_READ && bits == 3'd0 && rise && !control_serial_out_oe_n_o) begin
          tx <= reg_rdata_i;
          reg_read_o <= 1'b1;
        end
        if (state != ST_READ && !sel_s)
          control_serial_out_oe_n_o <= 1'b1;
      end else begin
        if (start) begin
          state <= ST_ADDR;
          bits <= 3'd0;
          sda_oe_n_o <= 1'b1;
        end else if (stop) begin
          state <= ST_IDLE;
          sda_oe_n_o <= 1'b1;
        end else if (rise) begin
          case (state)
            ST_ADDR, ST_PTR, ST_DATA: begin
              shift <= byte_in;
              bits <= bits + 3'd1;
              if (bits == 3'd7) begin
                after_ack <= ST_IDLE;
                if (state == ST_ADDR) begin
                  if (byte_in[7:1] == i2c_addr) begin
                    rw <= byte_in[0];
                    after_ack <= byte_in[0] ? ST_READ : ST_PTR;
                    state <= ST_ACK;
                  end else
                    state <= ST_IDLE;
                end else if (state == ST_PTR) begin
                  pointer_auto_step_o <= byte_in[`PTR_STEP_BIT];
                  reg_addr_o <= byte_in[6:0];
                  after_ack <= ST_DATA;
                  state <= ST_ACK;
                end else begin
                  reg_wdata_o <= byte_in;
                  reg_write_o <= 1'b1;
                  after_ack <= ST_DATA;
                  state <= ST_ACK;
                end
              end
            end
            ST_READ: begin
              bits <= bits + 3'd1;
              if (bits == 3'd7)
                state <= ST_RACK;
            end
            ST_RACK: begin
              if (s_sda[1])
                state <= ST_IDLE;
              else begin
                state <= ST_READ;
                bits <= 3'd0;
              end
              if (step)
                reg_addr_o <= reg_addr_o + 7'd1;
            end
            ST_ACK: state <= after_ack;
            default: state <= state;
          endcase
        end else if (fall) begin
          case (state)
            ST_ACK: begin
              sda_o <= 1'b0;
              sda_oe_n_o <= 1'b0;
              bits <= 3'd0;
            end
            ST_READ: begin
              if (bits == 3'd0) begin
                sda_o <= reg_rdata_i[7];
                tx <= {reg_rdata_i[6:0], 1'b0};
                reg_read_o <= 1'b1;
              end else begin
                sda_o <= tx[7];
                tx <= {tx[6:0], 1'b0};
              end
              sda_oe_n_o <= reg_rdata_i[7] & (bits == 3'd0) | tx[7] & (bits != 3'd0);
            end
            ST_RACK: sda_oe_n_o <= 1'b1;
            default: sda_oe_n_o <= 1'b1;
          endcase
          if (reg_write_o && step)
            reg_addr_o <= reg_addr_o + 7'd1;
        end else if (reg_write_o && step) begin
          reg_addr_o <= reg_addr_o + 7'd1;
        end
      end
    end
  end
  wire [N_IRQ-1:0] status;
  wire any;
  irq_source_logic #(.N(N_IRQ)) u_irq (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .cond_i(irq_cond_i),
    .mask_i(irq_mask_i),
    .trig_i(irq_trig_i),
    .clear_i(irq_clear_i),
    .status_o(status),
    .any_o(any)
  );
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
      irq_oe_n_o <= 1'b0;
      irq_status_o <= {N_IRQ{1'b0}};
    end else begin
      irq_status_o <= status;
      case (irq_pin_drive_select_i)
        `IRQ_ACT_HIGH: begin
          irq_o <= any;
          irq_oe_n_o <= 1'b0;
        end
        `IRQ_ACT_LOW: begin
          irq_o <= ~any;
          irq_oe_n_o <= 1'b0;
        end
        `IRQ_OPEN_DRAIN: begin
          irq_o <= 1'b0;
          irq_oe_n_o <= ~any;
        end
        default: begin
          irq_o <= 1'b0;
          irq_oe_n_o <= 1'b1;
        end
      endcase
    end
  end
endmodule // serial_control_port

/* core/serial_control_port_consts.vh */
// constants for the serial control port
`ifndef SERIAL_CONTROL_PORT_CONSTS_VH
`define SERIAL_CONTROL_PORT_CONSTS_VH
`define SPI_CHIP_ADDR 7'h10
`define I2C_ADDR_HI 4'h2
`define PTR_STEP_BIT 7
`define PTR_RESET 8'h00
`define IRQ_ACT_HIGH 2'h0
`define IRQ_ACT_LOW 2'h1
`define IRQ_OPEN_DRAIN 2'h2
`define TRIG_RISE 2'h0
`define TRIG_FALL 2'h1
`define TRIG_LEVEL 2'h2
`define MODE_NONE 2'h0
`define MODE_SPI 2'h1
`define MODE_I2C 2'h2
`endif

/* core/irq_source_logic.v */
// per-source interrupt trigger and mask logic
`timescale 1ns/1ps
`include "serial_control_port_consts.vh"
module irq_source_logic #(
  parameter N = 8
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire [N-1:0] cond_i,
  input wire [N-1:0] mask_i,
  input wire [2*N-1:0] trig_i,
  input wire [N-1:0] clear_i,
  output wire [N-1:0] status_o,
  output wire any_o
);
  reg [N-1:0] prev;
  reg [N-1:0] status;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : src
      wire [1:0] t = trig_i[2*g+1:2*g];
      wire hit = (t == `TRIG_RISE) ? (cond_i[g] & ~prev[g]) :
                 (t == `TRIG_FALL) ? (~cond_i[g] & prev[g]) :
                 (t == `TRIG_LEVEL) ? cond_i[g] : 1'b0;
      always @(posedge clock_i) begin
        if (!rst_n_i) begin
          prev[g] <= 1'b0;
          status[g] <= 1'b0;
        end else begin
          prev[g] <= cond_i[g];
          if (hit)
            status[g] <= 1'b1;
          else if (clear_i[g])
            status[g] <= 1'b0;
        end
      end
    end
  endgenerate
  assign status_o = status;
  assign any_o = |(status & mask_i);
endmodule // irq_source_logic

/* tb/serial_control_port_sva.sv */
// assertion checker for the serial control port
`timescale 1ns/1ps
module serial_control_port_sva (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic addr0_or_select_pin_i,
  input wire logic [1:0] irq_pin_drive_select_i,
  input wire logic control_serial_out_oe_n_o,
  input wire logic reg_write_o,
  input wire logic reg_read_o,
  input wire logic [1:0] port_mode_o,
  input wire logic irq_o,
  input wire logic irq_oe_n_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_oe_in_reset: assert property (disable iff (1'b0)
    !rst_n_i |=> control_serial_out_oe_n_o) else $error("data out driven in reset");
  a_mode_lock: assert property (port_mode_o != 2'h0 |=> $stable(port_mode_o))
    else $error("port mode changed");
  a_idle_hiz: assert property ((port_mode_o == 2'h1 && addr0_or_select_pin_i)[*8]
    |-> control_serial_out_oe_n_o) else $error("data out driven while deselected");
  a_od_low: assert property (
    ($stable(irq_pin_drive_select_i) && irq_pin_drive_select_i == 2'h2)[*2]
    |-> (irq_oe_n_o || !irq_o)) else $error("open drain pin driven high");
  a_pp_drive: assert property (
    ($stable(irq_pin_drive_select_i) && !irq_pin_drive_select_i[1])[*2]
    |-> !irq_oe_n_o) else $error("push pull pin released");
  a_off_release: assert property (
    ($stable(irq_pin_drive_select_i) && irq_pin_drive_select_i == 2'h3)[*2]
    |-> irq_oe_n_o) else $error("reserved pin mode drives");
  a_wr_pulse: assert property (reg_write_o |=> !reg_write_o)
    else $error("write strobe longer than one cycle");
  a_rd_pulse: assert property (reg_read_o |=> !reg_read_o)
    else $error("read strobe longer than one cycle");
endmodule // serial_control_port_sva
bind serial_control_port serial_control_port_sva i_serial_control_port_sva (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .addr0_or_select_pin_i(addr0_or_select_pin_i),
  .irq_pin_drive_select_i(irq_pin_drive_select_i), .reg_read_o(reg_read_o),
  .control_serial_out_oe_n_o(control_serial_out_oe_n_o), .reg_write_o(reg_write_o),
  .port_mode_o(port_mode_o), .irq_o(irq_o), .irq_oe_n_o(irq_oe_n_o));

/* tb/host_spi_model.sv */
// host side spi master model for the control port pins
`timescale 1ns/1ps
module host_spi_model (
  output logic sel_n_o,
  output logic control_bit_clock_o,
  output logic din_o,
  output logic sda_o,
  input wire logic sda_i,
  input wire logic dout_i,
  input wire logic dout_oe_n_i
);
  initial begin
    sel_n_o = 1'b1;
    control_bit_clock_o = 1'b1;
    din_o = 1'b0;
    sda_o = 1'b1;
  end
  task i2c_start();
    sda_o = 1'b0;
    #32 control_bit_clock_o = 1'b0;
  endtask
  task i2c_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
      output logic ack);
    rx = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      sda_o = tx[i];
      #32 control_bit_clock_o = 1'b1;
      rx = {rx[6:0], sda_i};
      #32 control_bit_clock_o = 1'b0;
    end
    sda_o = ack_in;
    #32 control_bit_clock_o = 1'b1;
    ack = sda_i;
    #32 control_bit_clock_o = 1'b0;
  endtask
  task i2c_stop();
    sda_o = 1'b0;
    #32 control_bit_clock_o = 1'b1;
    #32 sda_o = 1'b1;
    #64;
  endtask
  task open_frame();
    #64 sel_n_o = 1'b0;
    #64;
  endtask
  task xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      control_bit_clock_o = 1'b0;
      din_o = tx[i];
      #32 control_bit_clock_o = 1'b1;
      #32 rx = {rx[6:0], dout_oe_n_i ? 1'bx : dout_i};
    end
    din_o = ~din_o;
  endtask
  task close_frame();
    #64 sel_n_o = 1'b1;
    din_o = ~din_o;
    #256;
  endtask
endmodule // host_spi_model

/* tb/serial_control_port_tb.sv */
// self-checking testbench for the serial control port
`timescale 1ns/1ps
module serial_control_port_tb;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic writing = 1'b0;
  logic [1:0] drv = 2'h0;
  logic [7:0] cond = 8'h00;
  logic [7:0] mask = 8'h00;
  logic [7:0] clr = 8'h00;
  logic [15:0] trig = 16'haaaa;
  logic [7:0] idle_pin = 8'b1010_0100;
  logic [7:0] act_pin = 8'b1000_0001;
  logic [7:0] rx;
  logic [7:0] rxq [$];
  logic [14:0] wlog [0:15];
  int err_count = 0;
  int n_checks = 0;
  int nw = 0;
  int cyc = 0;
  int nrd = 0;
  int nrd0 = 0;
  logic ad1 = 1'b0;
  logic ack;
  wire sel_n, control_bit_clock, din, dout, dout_oe_n, wr, auto, irq, irq_oe_n;
  wire host_sda, dev_sda, dev_sda_oe_n, rd, sda_line;
  wire [6:0] addr;
  wire [7:0] wdata;
  wire [7:0] stat;
  wire [1:0] mode;
  initial forever #4 clock_i = ~clock_i;
  assign sda_line = host_sda & (dev_sda_oe_n | dev_sda);
  serial_control_port #(.N_IRQ(8)) i_serial_control_port (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .control_bit_clock_i(control_bit_clock),
    .control_serial_in_i(din), .sda_i(sda_line), .addr0_or_select_pin_i(sel_n),
    .address_bit1_pin_i(ad1), .emphasis_flag_pin_i(1'b1),
    .reg_rdata_i({1'b0, addr} ^ 8'h5a), .irq_pin_drive_select_i(drv),
    .irq_cond_i(cond), .irq_mask_i(mask), .irq_trig_i(trig), .irq_clear_i(clr),
    .control_serial_out_o(dout), .control_serial_out_oe_n_o(dout_oe_n), .sda_o(dev_sda),
    .sda_oe_n_o(dev_sda_oe_n), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_write_o(wr),
    .reg_read_o(rd), .port_mode_o(mode), .pointer_auto_step_o(auto), .irq_o(irq),
    .irq_oe_n_o(irq_oe_n), .irq_status_o(stat));
  host_spi_model i_host_spi_model (.sel_n_o(sel_n), .control_bit_clock_o(control_bit_clock), .din_o(din),
    .sda_o(host_sda), .sda_i(sda_line), .dout_i(dout), .dout_oe_n_i(dout_oe_n));
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_of_test();
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task run_frame(input logic [7:0] a, b, c, d, input int n);
    logic [7:0] t [4];
    t = '{a, b, c, d};
    rxq.delete();
    i_host_spi_model.open_frame();
    for (int k = 0; k < n; k++) begin
      i_host_spi_model.xfer(t[k], 8, rx);
      rxq.push_back(rx);
    end
    i_host_spi_model.close_frame();
  endtask
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (wr === 1'b1) begin
      wlog[nw] <= {addr, wdata};
      nw <= nw + 1;
    end
    if (rd === 1'b1) nrd <= nrd + 1;
    if (writing && dout_oe_n !== 1'b1) chk("hiz", dout_oe_n, 1'b1);
    if (cyc > 20000) begin
      err_count = err_count + 1;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (6) @(negedge clock_i);
    writing = 1'b1;
    run_frame(8'h20, 8'h85, 8'ha5, 8'h3c, 4);
    chk("mode", mode, 2'h1);
    chk("step", auto, 1'b1);
    chk("wr0", wlog[0], {7'h05, 8'ha5});
    chk("wr1", wlog[1], {7'h06, 8'h3c});
    run_frame(8'h30, 8'h02, 8'h11, 8'h00, 3);
    i_host_spi_model.open_frame();
    i_host_spi_model.xfer(8'h20, 8, rx);
    i_host_spi_model.xfer(8'h02, 8, rx);
    i_host_spi_model.xfer(8'hff, 5, rx);
    i_host_spi_model.close_frame();
    chk("nw", nw[15:0], 16'd2);
    run_frame(8'h20, 8'h02, 8'h77, 8'h00, 3);
    chk("wr2", wlog[2], {7'h02, 8'h77});
    run_frame(8'h20, 8'h07, 8'h00, 8'h00, 2);
    writing = 1'b0;
    run_frame(8'h21, 8'h00, 8'h00, 8'h00, 3);
    chk("rd0", rxq[1], 8'h5d);
    chk("rd1", rxq[2], 8'h5d);
    writing = 1'b1;
    run_frame(8'h20, 8'h8a, 8'h00, 8'h00, 2);
    writing = 1'b0;
    run_frame(8'h21, 8'h00, 8'h00, 8'h00, 3);
    chk("rd2", rxq[1], 8'h50);
    chk("rd3", rxq[2], 8'h51);
    chk("nw", nw[15:0], 16'd3);
    cond = 8'h01;
    for (int m = 0; m < 2; m++) begin
      for (int d = 0; d < 4; d++) begin
        @(negedge clock_i);
        mask = m[7:0];
        drv = d[1:0];
        repeat (6) @(negedge clock_i);
        chk("pin", {irq_oe_n, irq & ~irq_oe_n}, m ? act_pin[2*d+:2] : idle_pin[2*d+:2]);
      end
    end
    @(negedge clock_i);
    trig = 16'haa86;
    mask = 8'h06;
    cond = 8'h02;
    clr = 8'hff;
    repeat (4) @(negedge clock_i);
    clr = 8'h00;
    repeat (4) @(negedge clock_i);
    chk("held", stat[2:1], 2'b00);
    cond = 8'h04;
    repeat (6) @(negedge clock_i);
    chk("edge", stat[2:1], 2'b11);
    // second reset: unlock the mode and run the two-wire link
    rst_n_i = 1'b0;
    ad1 = 1'b1;
    repeat (2) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (6) @(negedge clock_i);
    i_host_spi_model.i2c_start();
    i_host_spi_model.i2c_byte(8'h2e, 1'b1, rx, ack);
    chk("ack0", ack, 1'b0);
    i_host_spi_model.i2c_byte(8'h83, 1'b1, rx, ack);
    chk("ack1", ack, 1'b0);
    i_host_spi_model.i2c_byte(8'h44, 1'b1, rx, ack);
    i_host_spi_model.i2c_byte(8'h45, 1'b1, rx, ack);
    i_host_spi_model.i2c_stop();
    chk("mode2", mode, 2'h2);
    chk("wr3", wlog[3], {7'h03, 8'h44});
    chk("wr4", wlog[4], {7'h04, 8'h45});
    i_host_spi_model.i2c_start();
    i_host_spi_model.i2c_byte(8'h2a, 1'b1, rx, ack);
    chk("nak", ack, 1'b1);
    i_host_spi_model.i2c_stop();
    i_host_spi_model.i2c_start();
    i_host_spi_model.i2c_byte(8'h2e, 1'b1, rx, ack);
    i_host_spi_model.i2c_byte(8'h89, 1'b1, rx, ack);
    i_host_spi_model.i2c_stop();
    i_host_spi_model.i2c_start();
    i_host_spi_model.i2c_byte(8'h2f, 1'b1, rx, ack);
    chk("ack2", ack, 1'b0);
    nrd0 = nrd;
    i_host_spi_model.i2c_byte(8'hff, 1'b0, rx, ack);
    chk("rd4", rx, 8'h53);
    i_host_spi_model.i2c_byte(8'hff, 1'b1, rx, ack);
    chk("rd5", rx, 8'h50);
    i_host_spi_model.i2c_stop();
    chk("fetch", 16'(nrd - nrd0), 16'd2);
    chk("nw2", nw[15:0], 16'd5);
    end_of_test();
  end
endmodule // serial_control_port_tb
